/* pkg/srrc_pkg.sv */
package srrc_pkg;
   // ==========================================================
   // Clock and stepping rates
   // ==========================================================
   localparam int CLK_HZ = 125000000;
   localparam int RATE_FLOOR_HZ = 100;
   localparam int RATE_STEP_HZ = 50;
   localparam int RATE_ROT_MAX_HZ = 1000;
   localparam int RATE_FOC_MAX_HZ = 500;
   localparam int RATE_FALLBACK_HZ = 250;
   localparam logic [10:0] RATE_FLOOR = 11'd100;
   localparam logic [10:0] RATE_STEP = 11'd50;
   localparam logic [10:0] RATE_ROT_MAX = 11'd1000;
   localparam logic [10:0] RATE_FOC_MAX = 11'd500;
   localparam logic [10:0] RATE_FALLBACK = 11'd250;
   // Steps spent at each rate before the next ramp increment.
   localparam logic [7:0] STEPS_PER_RATE = 8'h04;
   // Step pulse width on the translator input.
   localparam int PULSE_NS = 1000;
   localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   // Position readout width and half turn of the rotation axis.
   localparam int POS_W = 14;
   localparam logic [POS_W-1:0] POS_HALF = 14'h2000;
   // Stall watch: steps issued with no readout movement.
   localparam logic [7:0] STALL_STEPS = 8'h10;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      SRRC_IDLE = 3'b000,
      SRRC_WAKE = 3'b001,
      SRRC_RUN = 3'b010,
      SRRC_DONE = 3'b011,
      SRRC_SHUT = 3'b100
   } srrc_state_t;

   typedef struct packed {
      logic step_cw;
      logic step_ccw;
      logic power_on;
      logic brake_release;
   } srrc_drive_t;
endpackage : srrc_pkg

/* hdl/srrc_top.sv */
`timescale 1ns/10ps
// How it works
// - Each step is one pulse on either the clockwise or the counter-clockwise output.
// - Stepping never runs below the floor rate, and every move starts at it.
// - The rate rises in fixed increments up to the axis ceiling, higher for rotation.
// - The rate falls in fixed decrements down to the floor as convergence rate.
// - Deceleration starts once the remaining distance is at or below the steps needed to slow down.
// - On completion the brake engages and translator power is removed.
// - A first stall drops the rate to the floor and caps later ramps at the fallback rate.
// - A second stall stops stepping and shuts the drive down.
// - Rotation moves take the direction of the smaller angle.
// - An active limit blocks steps into it but allows steps away from it.
module srrc_top (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Axis select: high for rotation, low for focus
   input wire logic AXIS_ROT,
   // Command
   input wire logic CMD_GO,
   input wire logic [13:0] CMD_TARGET,
   // Position readout and limits from the mount
   input wire logic [13:0] POS_IN,
   input wire logic LIMIT_CW_IN,
   input wire logic LIMIT_CCW_IN,
   // Translator and switching outputs
   output srrc_pkg::srrc_drive_t DRIVE,
   // Status
   output logic BUSY,
   output logic DONE_PULSE,
   output logic SHUTDOWN
);
   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [13:0] pos_s1_reg, pos_s2_reg;
   logic [13:0] pos_s3_reg, pos_hold_reg;
   logic [1:0] lim_s1_reg, lim_s2_reg;
   logic axis_s1_reg, axis_s2_reg;

   // Mount signals arrive from another domain; two flops each.
   always_ff @(posedge CLK) begin
      pos_s1_reg <= POS_IN;
      pos_s2_reg <= pos_s1_reg;
      lim_s1_reg <= {LIMIT_CCW_IN, LIMIT_CW_IN};
      lim_s2_reg <= lim_s1_reg;
      axis_s1_reg <= AXIS_ROT;
      axis_s2_reg <= axis_s1_reg;
   end

   // The readout is a multi-bit word from another domain, so its bits may land in
   // different cycles; a value is only taken once two samples in a row agree.
   always_ff @(posedge CLK) begin
      pos_s3_reg <= pos_s2_reg;
      if (pos_s2_reg == pos_s3_reg) begin
         pos_hold_reg <= pos_s2_reg;
      end
   end

   // ==========================================================
   // State and registers
   // ==========================================================
   srrc_pkg::srrc_state_t state_reg, state_next;
   logic [10:0] rate_reg, rate_next;
   logic [26:0] acc_reg, acc_next;
   logic [7:0] dwell_reg, dwell_next;
   logic [7:0] stall_cnt_reg, stall_cnt_next;
   logic [13:0] last_pos_reg, last_pos_next;
   logic [13:0] target_reg, target_next;
   logic fallback_reg, fallback_next;
   logic dir_cw_reg, dir_cw_next;
   logic [7:0] pulse_reg, pulse_next;
   logic [15:0] decel_steps_reg, decel_steps_next;
   srrc_pkg::srrc_drive_t drive_reg, drive_next;
   logic done_reg, done_next;
   logic shut_reg, shut_next;

   // Modular distance in the chosen direction.
   function automatic logic [13:0] dist_f(input logic [13:0] a, input logic [13:0] b);
      dist_f = b - a;
   endfunction : dist_f

   // ==========================================================
   // Decoding
   // ==========================================================
   wire [13:0] fwd_dist = dist_f(pos_hold_reg, target_reg);
   wire [13:0] rev_dist = dist_f(target_reg, pos_hold_reg);
   wire rot_cw = (fwd_dist < srrc_pkg::POS_HALF);
   // Focus has no wrap: clockwise means upward to a larger count.
   wire foc_cw = (target_reg > pos_hold_reg);
   wire dir_pick = axis_s2_reg ? rot_cw : foc_cw;
   wire [13:0] remain = dir_cw_reg ? fwd_dist : rev_dist;
   wire at_target = (pos_hold_reg == target_reg);
   // ceiling by axis, capped during fallback
   wire [10:0] axis_max = axis_s2_reg ? srrc_pkg::RATE_ROT_MAX : srrc_pkg::RATE_FOC_MAX;
   wire [10:0] rate_cap = fallback_reg ? srrc_pkg::RATE_FALLBACK : axis_max;
   // limit blocks motion into it only
   wire blocked = dir_cw_reg ? lim_s2_reg[0] : lim_s2_reg[1];
   // Phase accumulator: one overflow per step at rate_reg steps per second.
   wire [27:0] acc_sum = {1'b0, acc_reg} + {17'h00000, rate_reg};
   wire step_tick = (acc_sum >= 28'(srrc_pkg::CLK_HZ));
   // steps needed to come back down to the floor
   wire near_set = ({2'b00, remain} <= decel_steps_reg);
   wire can_up = (rate_reg + srrc_pkg::RATE_STEP) <= rate_cap;
   wire can_down = rate_reg > srrc_pkg::RATE_FLOOR;
   wire moved = (pos_hold_reg != last_pos_reg);

   // ==========================================================
   // Next-state logic
   // ==========================================================
   always_comb begin
      state_next = state_reg;
      rate_next = rate_reg;
      acc_next = acc_reg;
      dwell_next = dwell_reg;
      stall_cnt_next = stall_cnt_reg;
      last_pos_next = last_pos_reg;
      target_next = target_reg;
      fallback_next = fallback_reg;
      dir_cw_next = dir_cw_reg;
      pulse_next = (pulse_reg != 8'h00) ? pulse_reg - 8'h01 : 8'h00;
      decel_steps_next = decel_steps_reg;
      drive_next = drive_reg;
      done_next = 1'b0;
      shut_next = shut_reg;
      if (pulse_reg == 8'h01) begin
         drive_next.step_cw = 1'b0;
         drive_next.step_ccw = 1'b0;
      end
      case (state_reg)
         srrc_pkg::SRRC_IDLE: begin
            if (CMD_GO) begin
               target_next = CMD_TARGET;
               shut_next = 1'b0;
               fallback_next = 1'b0;
               drive_next.power_on = 1'b1;
               drive_next.brake_release = 1'b1;
               state_next = srrc_pkg::SRRC_WAKE;
            end
         end
         srrc_pkg::SRRC_WAKE: begin
            // every move starts at the floor
            rate_next = srrc_pkg::RATE_FLOOR;
            acc_next = 27'h0000000;
            dwell_next = 8'h00;
            stall_cnt_next = 8'h00;
            decel_steps_next = 16'h0000;
            last_pos_next = pos_hold_reg;
            dir_cw_next = dir_pick;
            state_next = srrc_pkg::SRRC_RUN;
         end
         srrc_pkg::SRRC_RUN: begin
            if (at_target) begin
               state_next = srrc_pkg::SRRC_DONE;
            end else if (step_tick) begin
               acc_next = 27'(acc_sum - 28'(srrc_pkg::CLK_HZ));
               if (!blocked) begin
                  drive_next.step_cw = dir_cw_reg;
                  drive_next.step_ccw = !dir_cw_reg;
                  pulse_next = 8'(srrc_pkg::PULSE_CYC);
               end
               if (moved) begin
                  stall_cnt_next = 8'h00;
                  last_pos_next = pos_hold_reg;
               end else if (!blocked) begin
                  stall_cnt_next = stall_cnt_reg + 8'h01;
               end
               dwell_next = dwell_reg + 8'h01;
               if (!moved && !blocked && stall_cnt_reg + 8'h01 >= srrc_pkg::STALL_STEPS) begin
                  if (fallback_reg) begin
                     shut_next = 1'b1;
                     state_next = srrc_pkg::SRRC_DONE;
                  end else begin
                     // drop to floor, cap at fallback
                     fallback_next = 1'b1;
                     rate_next = srrc_pkg::RATE_FLOOR;
                     decel_steps_next = 16'h0000;
                     stall_cnt_next = 8'h00;
                     dwell_next = 8'h00;
                  end
               end else if (dwell_reg + 8'h01 >= srrc_pkg::STEPS_PER_RATE) begin
                  dwell_next = 8'h00;
                  if (near_set && can_down) begin
                     rate_next = rate_reg - srrc_pkg::RATE_STEP;
                     decel_steps_next = decel_steps_reg - 16'(srrc_pkg::STEPS_PER_RATE);
                  end else if (!near_set && can_up) begin
                     rate_next = rate_reg + srrc_pkg::RATE_STEP;
                     decel_steps_next = decel_steps_reg + 16'(srrc_pkg::STEPS_PER_RATE);
                  end
               end
            end
         end
         srrc_pkg::SRRC_DONE: begin
            drive_next = '0;
            done_next = 1'b1;
            state_next = shut_reg ? srrc_pkg::SRRC_SHUT : srrc_pkg::SRRC_IDLE;
         end
         srrc_pkg::SRRC_SHUT: begin
            // Stays down until a new command is issued.
            drive_next = '0;
            if (CMD_GO) begin
               state_next = srrc_pkg::SRRC_IDLE;
            end
         end
         default: begin
            state_next = srrc_pkg::SRRC_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_reg <= srrc_pkg::SRRC_IDLE;
         rate_reg <= srrc_pkg::RATE_FLOOR;
         acc_reg <= '0;
         dwell_reg <= '0;
         stall_cnt_reg <= '0;
         last_pos_reg <= '0;
         target_reg <= '0;
         fallback_reg <= 1'b0;
         dir_cw_reg <= 1'b0;
         pulse_reg <= '0;
         decel_steps_reg <= '0;
         drive_reg <= '0;
         done_reg <= 1'b0;
         shut_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         rate_reg <= rate_next;
         acc_reg <= acc_next;
         dwell_reg <= dwell_next;
         stall_cnt_reg <= stall_cnt_next;
         last_pos_reg <= last_pos_next;
         target_reg <= target_next;
         fallback_reg <= fallback_next;
         dir_cw_reg <= dir_cw_next;
         pulse_reg <= pulse_next;
         decel_steps_reg <= decel_steps_next;
         drive_reg <= drive_next;
         done_reg <= done_next;
         shut_reg <= shut_next;
      end
   end

   // DRIVE, DONE_PULSE and SHUTDOWN come straight from flops; BUSY is decoded from the state.
   assign DRIVE = drive_reg;
   assign DONE_PULSE = done_reg;
   assign SHUTDOWN = shut_reg;
   assign BUSY = (state_reg != srrc_pkg::SRRC_IDLE) && (state_reg != srrc_pkg::SRRC_SHUT);
endmodule : srrc_top

/* bench/srrc_top_sva.sv */
`timescale 1ns/10ps
// ==========================================================
// Drive output checks
// ==========================================================
module srrc_chk (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Watched ports
   input wire logic CMD_GO,
   input wire logic LIMIT_CW_IN,
   input wire srrc_pkg::srrc_drive_t DRIVE,
   input wire logic BUSY,
   input wire logic DONE_PULSE,
   input wire logic SHUTDOWN
);
   logic step_any;
   logic [7:0] hi_reg;
   logic [20:0] gap_reg;
   // Pulse length and low gap in cycles; the gap saturates so the first step always passes.
   assign step_any = DRIVE.step_cw | DRIVE.step_ccw;
   always_ff @(posedge CLK) begin
      hi_reg <= (RST || !step_any) ? 8'h00 : hi_reg + 8'h01;
      gap_reg <= RST ? 21'h1FFFFF : step_any ? 21'h00000 : gap_reg + 21'(gap_reg != 21'h1FFFFF);
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // A truncated pulse at completion is tolerated, since the drive is dropped whole then.
   a_step_exclusive: assert property (!(DRIVE.step_cw && DRIVE.step_ccw))
      else $error("both step outputs high");
   a_pulse_width: assert property ($fell(step_any) && !DONE_PULSE |-> hi_reg == 8'h7D)
      else $error("step pulse width wrong");
   a_rate_ceiling: assert property ($rose(step_any) |-> gap_reg >= 21'h1E7CB)
      else $error("steps closer than the ceiling rate");
   a_step_powered: assert property (step_any |-> DRIVE.power_on && DRIVE.brake_release)
      else $error("step without power or brake release");
   a_go_powers: assert property (CMD_GO && !BUSY && !SHUTDOWN && !DONE_PULSE
      |=> DRIVE.power_on && DRIVE.brake_release && BUSY)
      else $error("accepted command did not power the drive");
   a_done_release: assert property (DONE_PULSE |-> DRIVE == 4'h0 ##1 !DONE_PULSE)
      else $error("completion left drive on");
   a_limit_blocks: assert property (LIMIT_CW_IN [*5] |-> !$rose(DRIVE.step_cw))
      else $error("step into active limit");
   a_shut_still: assert property (SHUTDOWN |-> !step_any)
      else $error("step while shut down");
endmodule : srrc_chk

bind srrc_top srrc_chk chk_i (.CLK(CLK), .RST(RST), .CMD_GO(CMD_GO), .LIMIT_CW_IN(LIMIT_CW_IN),
   .DRIVE(DRIVE), .BUSY(BUSY), .DONE_PULSE(DONE_PULSE), .SHUTDOWN(SHUTDOWN));

/* bench/srrc_xlator_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Translator, motor and readout model
// ==========================================================
module srrc_xlator_model #(
   parameter logic [13:0] START_POS = 14'h0123
) (
   // Clock and drive in
   input wire logic clk,
   input wire srrc_pkg::srrc_drive_t drive,
   input wire logic stall,
   // Position readout
   output logic [13:0] pos
);
   logic cw_reg = 1'b0;
   logic ccw_reg = 1'b0;
   logic free;
   logic [13:0] pos_reg = START_POS;
   assign free = drive.power_on & drive.brake_release & !stall;
   assign pos = pos_reg;
   // one count per pulse; a stalled motor leaves the readout still.
   always @(posedge clk) begin
      cw_reg <= drive.step_cw;
      ccw_reg <= drive.step_ccw;
      if (free && drive.step_cw && !cw_reg) pos_reg <= pos_reg + 14'h0001;
      if (free && drive.step_ccw && !ccw_reg) pos_reg <= pos_reg - 14'h0001;
   end
endmodule : srrc_xlator_model

/* bench/stepper_rate_ramp_control_bench.sv */
`timescale 1ns/10ps
// ==========================================================
// Directed bench
// ==========================================================
module stepper_rate_ramp_control_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic axis_rot = 1'b0;
   logic cmd_go = 1'b0;
   logic [13:0] cmd_target = 14'h0000;
   logic lim_cw = 1'b0;
   logic lim_ccw = 1'b0;
   logic [13:0] pos;
   srrc_pkg::srrc_drive_t drive;
   logic busy;
   logic done_pulse;
   logic shutdown;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int step_cycles = 0;
   always #4 clk = ~clk;
   srrc_top uut (.CLK(clk), .RST(rst), .AXIS_ROT(axis_rot), .CMD_GO(cmd_go),
      .CMD_TARGET(cmd_target), .POS_IN(pos), .LIMIT_CW_IN(lim_cw), .LIMIT_CCW_IN(lim_ccw),
      .DRIVE(drive), .BUSY(busy), .DONE_PULSE(done_pulse), .SHUTDOWN(shutdown));
   srrc_xlator_model xlator (.clk(clk), .drive(drive), .stall(1'b0), .pos(pos));
   // Step activity and the hang guard; a full run needs about 80000 cycles.
   always @(posedge clk) begin
      cyc++;
      if (drive.step_cw || drive.step_ccw) step_cycles++;
      if (cyc == 100000) begin
         fail_count++;
         end_sim();
      end
   end
   // Inputs move one nanosecond after the rising edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   // Issue a command and check that power and brake release follow at once.
   task automatic go(input logic [13:0] t);
      cmd_target = t;
      cmd_go = 1'b1;
      tick(1);
      cmd_go = 1'b0;
      chk(16'({drive.power_on, drive.brake_release, busy}), 16'h0007);
   endtask : go
   task automatic t_reset_state();
      chk(16'(drive), 16'h0000);
      chk(16'({busy, done_pulse, shutdown}), 16'h0000);
      $display("test reset_state done");
   endtask : t_reset_state
   // A command already at its target completes without a step.
   task automatic t_on_target();
      int n;
      n = 0;
      go(pos);
      while (done_pulse !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk(16'({done_pulse, drive}), 16'h0010);
      tick(1);
      chk(16'({done_pulse, busy, drive}), 16'h0000);
      chk(16'(step_cycles), 16'h0000);
      $display("test on_target done");
   endtask : t_on_target
   // A move must start at the floor rate, so no step shows within 40000 cycles.
   task automatic t_move(input logic rot);
      int s0;
      axis_rot = rot;
      lim_cw = !rot;
      tick(4);
      s0 = step_cycles;
      go(pos + 14'h0040);
      cmd_go = 1'b1;
      tick(1);
      cmd_go = 1'b0;
      tick(40000);
      chk(16'(step_cycles - s0), 16'h0000);
      chk(16'({drive.power_on, drive.brake_release, busy}), 16'h0007);
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      lim_cw = 1'b0;
      chk(16'({drive, busy}), 16'h0000);
      $display("test move done");
   endtask : t_move
   initial begin
      tick(20);
      rst = 1'b0;
      tick(2);
      t_reset_state();
      t_on_target();
      t_move(1'b0);
      t_move(1'b1);
      end_sim();
   end
endmodule : stepper_rate_ramp_control_bench
